// ===== hdl/hwpm_defines.vh
// constants for the host watchdog and power mode controller
`ifndef HWPM_DEFINES_VH
`define HWPM_DEFINES_VH
`define HWPM_CLK_HZ        50000000
`define HWPM_WIN0_MS       100
`define HWPM_WIN1_MS       200
`define HWPM_WIN2_MS       500
`define HWPM_WIN3_MS       1000
`define HWPM_SEL_WIN0      2'h0
`define HWPM_SEL_WIN1      2'h1
`define HWPM_SEL_WIN2      2'h2
`define HWPM_SEL_WIN3      2'h3
`define HWPM_CLK_SEL_EXT   2'h3
`define HWPM_SRC_PIN       1'h0
`define HWPM_SRC_REG       1'h1
`define HWPM_ACT_REPORT    1'h0
`define HWPM_ACT_LATCH     1'h1
`define HWPM_MODE_STANDBY  1'h0
`define HWPM_MODE_SLEEP    1'h1
`define HWPM_CNT_W         26
`endif

// ===== hdl/hwpm_ctrl.v
// host watchdog, output kill, low power mode and clock source control
`timescale 1ns/10ps
`default_nettype none
`include "hwpm_defines.vh"

//----------------------------------------
// overview
//----------------------------------------
// supervision of a host controller by periodic tickles
// a tickle is a pin rising edge or a one-cycle set-bit pulse
// only the selected tickle source is looked at
// the interval timer counts clock cycles since the last tickle
// the timer also restarts when the watchdog is switched on
// the timer also restarts when a latched fault is cleared
// a timeout raises a one-cycle report pulse
// in latched mode the timeout also sets a sticky fault
// the sticky fault forces the outputs to high impedance
// the sticky fault also pulls the fault indicator low
// only the clear pulse or a disabled watchdog drops it
// a timeout in the same cycle as a clear wins over the clear
// no timeout can follow while the sticky fault stands
// the watchdog needs one cycle of enable before it can expire
//
// low power entry is decided outside and given as a request
// the select bit picks sleep or standby for that request
// the kill pin overrides any low power request
// sleep turns off switches, sense amps, supplies and the host bus
// standby turns off only the switches
// kill with speed high keeps supplies and the host bus alive
// kill always masks the overcurrent protection
//
// the fault indicator is low while the regulators are off
// it is also low for sleep, timeouts, a sticky fault, other faults
//
// the block always leaves reset on the internal oscillator
// the outside clock needs select 11b, the enable bit and a good clock
//
// every output is a flip-flop, so every effect is one cycle late
// hazard: a tickle landing on the expiry cycle suppresses the pulse
// limitation: interval lengths are whole clock cycles
// limitation: very short pin pulses below one cycle can be missed
// trade-off: the report pulse restarts the timer, so a dead host
//            in report mode produces one pulse per interval

module hwpm_ctrl
#(
   parameter [`HWPM_CNT_W-1:0] WIN0_CYC = `HWPM_CLK_HZ / 1000 * `HWPM_WIN0_MS,
   parameter [`HWPM_CNT_W-1:0] WIN1_CYC = `HWPM_CLK_HZ / 1000 * `HWPM_WIN1_MS,
   parameter [`HWPM_CNT_W-1:0] WIN2_CYC = `HWPM_CLK_HZ / 1000 * `HWPM_WIN2_MS,
   parameter [`HWPM_CNT_W-1:0] WIN3_CYC = `HWPM_CLK_HZ / 1000 * `HWPM_WIN3_MS
)
(
   input  wire       i_clk,
   input  wire       i_rst,
   input  wire       i_remote_supervisor_enable,
   input  wire       i_tickle_source_select,
   input  wire [1:0] i_tickle_window_select,
   input  wire       i_supervisor_fault_action,
   input  wire       i_tickle_pin,
   input  wire       i_tickle_set_bit,
   input  wire       i_fault_clear_bit,
   input  wire       i_other_fault,
   input  wire       i_output_kill_pin,
   input  wire       i_speed_pin,
   input  wire       i_low_power_req,
   input  wire       i_low_power_select,
   input  wire       i_regulators_ok,
   input  wire [1:0] i_clock_source_select,
   input  wire       i_outside_clock_enable,
   input  wire       i_outside_clock_ok,
   output reg        o_wd_timeout,
   output reg        o_wd_latched,
   output reg        o_outputs_hiz,
   output reg        o_switch_enable,
   output reg        o_overcurrent_protection_enable,
   output reg        o_sense_amp_enable,
   output reg        o_buck_enable,
   output reg        o_charge_pump_enable,
   output reg        o_ldo_enable,
   output reg        o_i2c_enable,
   output reg        o_sleep_active,
   output reg        o_standby_active,
   output reg        o_fault_indicator_pin_n,
   output reg        o_use_outside_clock
);

   //----------------------------------------
   // functions
   //----------------------------------------
   // interval length in cycles for a window selector code
   function [`HWPM_CNT_W-1:0] win_cycles;
      input [1:0] sel;
      begin
         case (sel)
            `HWPM_SEL_WIN0: win_cycles = WIN0_CYC;
            `HWPM_SEL_WIN1: win_cycles = WIN1_CYC;
            `HWPM_SEL_WIN2: win_cycles = WIN2_CYC;
            default:        win_cycles = WIN3_CYC;
         endcase
      end
   endfunction

   //----------------------------------------
   // tickle detection
   //----------------------------------------
   reg                   pin_d_r;
   reg                   en_d_r;
   reg [`HWPM_CNT_W-1:0] cnt_r;
   reg [`HWPM_CNT_W-1:0] cnt_nxt;
   reg                   started_r;
   wire                  pin_rise;
   wire                  tickle;
   wire                  en_rise;
   wire                  expire;
   wire                  clear_latch;

   // the pin history resets low, the idle level of the pin
   // so a pin held high through reset gives one edge on release
   // which only restarts the timer and is harmless
   // the set bit is a pulse per host write, so no edge detect
   // rising edge of the tickle pin
   assign pin_rise = i_tickle_pin & ~pin_d_r;
   // only the selected source counts
   assign tickle = (i_tickle_source_select == `HWPM_SRC_PIN) ? pin_rise
                 : i_tickle_set_bit;
   assign en_rise = i_remote_supervisor_enable & ~en_d_r;
   // fault clear releases a latched fault
   assign clear_latch = i_fault_clear_bit & o_wd_latched;
   // elapsed time beyond the interval
   assign expire = i_remote_supervisor_enable & started_r
                 & (cnt_r >= win_cycles(i_tickle_window_select));

   //----------------------------------------
   // interval timer
   //----------------------------------------
   // priority: disable, enable rise and clear first
   // then a tickle, then the expiry restart
   // a disabled watchdog keeps the counter at zero
   // so a fresh enable never sees a stale count
   // counter next value
   always @*
   begin
      cnt_nxt = cnt_r;
      if (!i_remote_supervisor_enable || en_rise || clear_latch)
         cnt_nxt = {`HWPM_CNT_W{1'b0}};
      else if (tickle)
         cnt_nxt = {`HWPM_CNT_W{1'b0}};
      else if (expire)
         cnt_nxt = {`HWPM_CNT_W{1'b0}}; // restart after a report
      else
         cnt_nxt = cnt_r + {{(`HWPM_CNT_W-1){1'b0}}, 1'b1};
   end

   // timer and edge history
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         pin_d_r   <= 1'b0;
         en_d_r    <= 1'b0;
         cnt_r     <= {`HWPM_CNT_W{1'b0}};
         started_r <= 1'b0;
      end
      else
      begin
         pin_d_r   <= i_tickle_pin;
         en_d_r    <= i_remote_supervisor_enable;
         cnt_r     <= cnt_nxt;
         started_r <= i_remote_supervisor_enable & ~o_wd_latched;
      end
   end

   //----------------------------------------
   // fault state
   //----------------------------------------
   // the pulse is dropped when a tickle lands on the expiry cycle
   // the host was in time then, only by a hair
   // dropping the enable also drops the sticky fault
   // report pulse and latched fault; new timeout wins over clear
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_wd_timeout <= 1'b0;
         o_wd_latched <= 1'b0;
      end
      else
      begin
         o_wd_timeout <= expire & ~tickle;
         if (expire && !tickle && i_supervisor_fault_action == `HWPM_ACT_LATCH)
            o_wd_latched <= 1'b1;
         else if (i_fault_clear_bit || !i_remote_supervisor_enable)
            o_wd_latched <= 1'b0;
      end
   end

   //----------------------------------------
   // power mode and output enables
   //----------------------------------------
   reg low_power;
   reg sleep;
   reg standby;
   reg kill_awake;

   // the kill pin wins over a low power request
   // both sleep and standby come from one request
   // mode decode
   always @*
   begin
      low_power  = i_low_power_req & ~i_output_kill_pin;
      sleep      = low_power & (i_low_power_select == `HWPM_MODE_SLEEP);
      standby    = low_power & (i_low_power_select == `HWPM_MODE_STANDBY);
      kill_awake = i_output_kill_pin & i_speed_pin;
   end

   // reset state: everything off, outputs high impedance
   // fault indicator low until the supplies come up
   // internal oscillator in use until configured otherwise
   // switches need no latched fault, no kill, no low power
   // supplies stay up unless sleep; kill with speed high also keeps them up
   // registered enables
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_outputs_hiz                   <= 1'b1;
         o_switch_enable                 <= 1'b0;
         o_overcurrent_protection_enable <= 1'b0;
         o_sense_amp_enable              <= 1'b0;
         o_buck_enable                   <= 1'b0;
         o_charge_pump_enable            <= 1'b0;
         o_ldo_enable                    <= 1'b0;
         o_i2c_enable                    <= 1'b0;
         o_sleep_active                  <= 1'b0;
         o_standby_active                <= 1'b0;
         o_fault_indicator_pin_n         <= 1'b0;
         o_use_outside_clock             <= 1'b0;
      end
      else
      begin
         o_outputs_hiz   <= o_wd_latched | i_output_kill_pin | sleep;
         o_switch_enable <= ~(o_wd_latched | i_output_kill_pin | sleep
                              | standby);
         o_overcurrent_protection_enable <= ~(i_output_kill_pin | sleep);
         o_sense_amp_enable   <= ~sleep;
         o_buck_enable        <= ~sleep | kill_awake;
         o_charge_pump_enable <= ~sleep | kill_awake;
         o_ldo_enable         <= ~sleep | kill_awake;
         o_i2c_enable         <= ~sleep | kill_awake;
         o_sleep_active       <= sleep;
         o_standby_active     <= standby;
         // pin low while supplies off or a fault is shown
         o_fault_indicator_pin_n <= i_regulators_ok & ~sleep & ~o_wd_latched
                                  & ~o_wd_timeout & ~i_other_fault;
         o_use_outside_clock <= (i_clock_source_select == `HWPM_CLK_SEL_EXT)
                              & i_outside_clock_enable & i_outside_clock_ok;
      end
   end

endmodule // hwpm_ctrl
`default_nettype wire

// ===== sim/hwpm_host_model.sv
// host model: watchdog tickles on the pin or the set bit
`timescale 1ns/10ps
`default_nettype none
module hwpm_host_model (
   input  wire logic       i_clk, i_go, i_src,
   input  wire logic [7:0] i_gap,
   output var  logic       o_pin = 1'b0, o_set = 1'b0
);
   logic [7:0] cnt_r = 8'h00;
   // one tickle every gap+1 cycles, changed just after the edge
   always @(posedge i_clk)
   begin
      cnt_r <= (i_go && cnt_r < i_gap) ? cnt_r + 8'h01 : 8'h00;
      o_pin <= i_go && cnt_r == i_gap && !i_src;
      o_set <= i_go && cnt_r == i_gap && i_src;
   end
endmodule // hwpm_host_model
`default_nettype wire

// ===== sim/hwpm_ctrl_monitor.sv
// checker of watchdog, kill pin, low power and clock source
`timescale 1ns/10ps
`default_nettype none
module hwpm_ctrl_monitor (
   input wire logic i_clk, i_rst, i_remote_supervisor_enable, i_fault_clear_bit,
   input wire logic i_output_kill_pin, i_speed_pin, i_low_power_req, i_low_power_select,
   input wire logic i_regulators_ok, i_outside_clock_enable, o_wd_timeout, o_wd_latched,
   input wire logic o_outputs_hiz, o_switch_enable, o_overcurrent_protection_enable,
   input wire logic o_i2c_enable, o_sleep_active, o_fault_indicator_pin_n, o_use_outside_clock,
   input wire logic [1:0] i_clock_source_select
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // latched trip: pulse and latch together
   sequence s_trip; o_wd_timeout && o_wd_latched; endsequence
   property p_off; !i_remote_supervisor_enable [*2] |-> !o_wd_timeout && !o_wd_latched;
   endproperty
   property p_trip; s_trip |=> o_outputs_hiz && !o_switch_enable; endproperty
   property p_hold; o_wd_latched && !i_fault_clear_bit && i_remote_supervisor_enable
      |=> o_wd_latched; endproperty
   property p_kill; i_output_kill_pin |=> !o_switch_enable; endproperty
   property p_kspd; i_output_kill_pin && i_speed_pin
      |=> o_i2c_enable && !o_overcurrent_protection_enable; endproperty
   property p_sleep; i_low_power_req && i_low_power_select && !i_output_kill_pin
      |=> o_sleep_active && !o_i2c_enable && !o_switch_enable; endproperty
   property p_flt; !i_regulators_ok |=> !o_fault_indicator_pin_n; endproperty
   property p_clk; o_use_outside_clock
      |-> $past(i_clock_source_select) == 2'h3 && $past(i_outside_clock_enable); endproperty
   a_off: assert property (p_off) else $error("watchdog while off");
   a_trip: assert property (p_trip) else $error("no hiz on trip");
   a_hold: assert property (p_hold) else $error("latch dropped");
   a_kill: assert property (p_kill) else $error("kill ignored");
   a_kspd: assert property (p_kspd) else $error("kill with speed");
   a_sleep: assert property (p_sleep) else $error("sleep state");
   a_flt: assert property (p_flt) else $error("fault pin");
   a_clk: assert property (p_clk) else $error("outside clock");
endmodule // hwpm_ctrl_monitor
bind hwpm_ctrl hwpm_ctrl_monitor u_hwpm_ctrl_monitor (.*);
`default_nettype wire

// ===== sim/hwpm_ctrl_test.sv
// bench of the watchdog and power mode controller
`timescale 1ns/10ps
`default_nettype none
module hwpm_ctrl_test;
   localparam int W[4] = '{20, 40, 100, 200};
   logic i_clk = 0, i_rst = 1, i_remote_supervisor_enable = 0, i_supervisor_fault_action = 0;
   logic i_tickle_source_select = 0, i_fault_clear_bit = 0, i_tickle_pin, i_tickle_set_bit;
   logic i_output_kill_pin, i_speed_pin, i_low_power_req, i_low_power_select, i_regulators_ok;
   logic i_other_fault, i_outside_clock_enable, i_outside_clock_ok, go = 0, msrc = 0;
   logic [1:0] i_tickle_window_select = 0, i_clock_source_select;
   logic o_wd_timeout, o_wd_latched, o_outputs_hiz, o_switch_enable, o_sense_amp_enable;
   logic o_overcurrent_protection_enable, o_buck_enable, o_charge_pump_enable, o_ldo_enable;
   logic o_i2c_enable, o_sleep_active, o_standby_active, o_fault_indicator_pin_n;
   logic o_use_outside_clock;
   logic [7:0] gap = 8'h10;
   logic [9:0] m = 10'h3D0;
   int cyc = 0, mark = 0, failures = 0, compares = 0, q[$], e, k, n;
   assign {i_clock_source_select, i_outside_clock_ok, i_outside_clock_enable, i_other_fault,
      i_regulators_ok, i_low_power_select, i_low_power_req, i_speed_pin, i_output_kill_pin} = m;
   always #10 i_clk = ~i_clk;
   hwpm_ctrl #(.WIN0_CYC(26'h14), .WIN1_CYC(26'h28), .WIN2_CYC(26'h64), .WIN3_CYC(26'hC8))
   u_hwpm_ctrl (.*);
   hwpm_host_model u_hwpm_host_model (.i_clk(i_clk), .i_go(go), .i_src(msrc), .i_gap(gap),
      .o_pin(i_tickle_pin), .o_set(i_tickle_set_bit));
   task automatic chk(input logic ok, input string s);
      compares++;
      if (ok !== 1'b1)
      begin
         failures++;
         $display("mismatch at %0t: %s", $time, s);
      end
   endtask
   task automatic tally_and_finish;
      if (failures == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // last tickle taken from the selected source
   always @(posedge i_clk)
   begin
      cyc++;
      if ((i_tickle_source_select ? i_tickle_set_bit : i_tickle_pin) === 1'b1)
         mark = cyc;
   end
   // each timeout takes the oldest expectation off the queue
   always @(negedge i_clk)
      if (o_wd_timeout === 1'b1)
      begin
         e = q.size() ? q.pop_front() : 4;
         chk(e < 4 && cyc - mark inside {[W[e % 4] : W[e % 4] + 3]}, "timeout time");
         chk(o_wd_latched === e[0], "latch on timeout");
      end
   initial
   begin
      void'($urandom(32'hCA94));
      repeat (16) @(negedge i_clk);
      chk(o_use_outside_clock === 1'b0 && o_fault_indicator_pin_n === 1'b0, "power up");
      i_rst = 0;
      m = 10'h010;
      for (k = 0; k < 4; k++)
      begin
         i_tickle_window_select = k[1:0];
         i_supervisor_fault_action = k[0];
         i_tickle_source_select = k[1];
         msrc = k[1];
         gap = 8'(2 + $urandom % (W[k] - 4));
         i_remote_supervisor_enable = 1;
         go = 1;
         repeat (4 * W[k]) @(negedge i_clk);
         msrc = k[0] ? !msrc : msrc;
         go = k[0];
         q.push_back(k);
         for (n = 0; n < 2 * W[k] + 20 && q.size() > 0; n++)
            @(negedge i_clk);
         if (q.size() > 0)
         begin
            chk(0, "timeout missing");
            tally_and_finish;
         end
         repeat (3) @(negedge i_clk);
         chk(o_outputs_hiz === k[0] && o_fault_indicator_pin_n === !k[0], "outputs");
         chk(o_wd_latched === k[0], "latch held");
         i_fault_clear_bit = 1;
         @(negedge i_clk);
         i_fault_clear_bit = 0;
         repeat (3) @(negedge i_clk);
         chk(o_wd_latched === 0 && o_outputs_hiz === 0 && o_switch_enable === 1, "release");
         i_remote_supervisor_enable = 0;
         go = 0;
         repeat (2) @(negedge i_clk);
      end
      // m bits: 0 kill, 1 speed, 2 req, 3 sel, 4 reg ok, 5 other, 6 ck en, 7 ck ok, 9:8 ck sel
      repeat (400)
      begin
         m = 10'($urandom);
         @(negedge i_clk);
         chk(o_sleep_active === (m[2] & m[3] & !m[0]), "sleep");
         chk(o_standby_active === (m[2] & !m[3] & !m[0]), "standby");
         chk(o_sense_amp_enable === !(m[2] & m[3] & !m[0]), "sense amp");
         chk(o_ldo_enable === (!(m[2] & m[3] & !m[0]) | (m[0] & m[1])), "ldo");
         chk(o_buck_enable === o_ldo_enable && o_charge_pump_enable === o_ldo_enable, "supplies");
         chk(o_switch_enable === !(m[0] | m[2]), "switches");
         chk(o_fault_indicator_pin_n === (m[4] & !(m[2] & m[3] & !m[0]) & !m[5]), "fault pin");
         chk(o_use_outside_clock === (m[9:8] == 2'h3 && m[6] && m[7]), "clock source");
      end
      tally_and_finish;
   end
endmodule // hwpm_ctrl_test
`default_nettype wire
